/* rtl/xdata_timing_pkg.sv */
// Constants and types for the external data access timing block
package xdata_timing_pkg;
	localparam int unsigned CLK_PER_MC = 4;
	localparam logic [7:0] PTR_SEL_ADDR = 8'h86;
	localparam logic [7:0] CLOCK_CTRL_ADDR = 8'h8e;
	localparam logic [7:0] MEM_MAP_ADDR = 8'h9c;
	localparam logic [7:0] TA_ADDR = 8'hc7;
	localparam logic [7:0] TA_KEY1 = 8'haa;
	localparam logic [7:0] TA_KEY2 = 8'h55;
	localparam int unsigned TA_WINDOW = 3;
	localparam int unsigned STRETCH_LSB = 0;
	localparam int unsigned WAIT_EN_BIT = 7;
	localparam logic [2:0] STRETCH_RESET = 3'h1;
	localparam logic [7:0] CLOCK_CTRL_RESET = 8'h01;
	localparam logic [1:0] SAMPLE_PHASE = 2'h2;
	localparam logic [1:0] STROBE_END_PHASE = 2'h3;

	typedef enum logic [1:0] {
		MOVE_READ_PTR,
		MOVE_WRITE_PTR,
		MOVE_READ_REG,
		MOVE_WRITE_REG
	} move_kind_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd_n;
		logic wr_n;
	} ext_bus_t;
endpackage

/* rtl/xdata_timing.sv */
// External data move sequencer with stretch, wait input and dual data pointers
`timescale 1ns/1ps
// Operation
// - Move begins with a four clock fetch; access happens in the next cycle.
// - Stretch field bits 2..0 of clock control sets 2 to 9 cycles.
// - Only external data moves are lengthened; other instructions keep their timing.
// - Stretch resets to 1 giving 3 cycles; 0 gives 2 cycles.
// - Strobe width is 2, 4, then 8 to 28 clocks by stretch value.
// - Wait input on port four bit zero, used only when wait enable set.
// - With wait enabled, stretch is minimum (not enforced here: stretch 0 to 7 still apply); wait sampled in third clock state.
// - Each active wait sample inserts one more cycle with strobe held.
// - Wait cycles unlimited; move ends one cycle after wait is seen inactive, or in that same cycle at stretch 0.
// - Wait enable changes only after the timed access unlock sequence.
// - Pointer select picks primary or secondary pointer for moves, loads, increments.
// - Pointer select is bit zero at 86h; other bits read zero.
// - Register indirect address is working register low, port two latch high.
// - Each machine cycle is four clocks; lengths counted in machine cycles.
module xdata_timing
	import xdata_timing_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Sequencer requests
	input wire logic move_start_i,
	input wire move_kind_t move_kind_i,
	input wire logic [7:0] move_wdata_i,
	input wire logic [7:0] work_reg_i,
	input wire logic [7:0] port2_latch_i,
	input wire logic ptr_load_i,
	input wire logic [15:0] ptr_load_val_i,
	input wire logic ptr_inc_i,
	output logic move_busy_o,
	output logic move_done_o,
	output logic [7:0] move_rdata_o,
	output logic [15:0] sel_ptr_o,
	// External bus
	input wire logic [7:0] ext_rdata_i,
	input wire logic port4_bit0_pin_n_i,
	output ext_bus_t ext_bus_o
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_ACCESS
	} seq_state_t;

	seq_state_t state_q;
	logic [1:0] phase_q;
	logic [3:0] mc_left_q;
	logic [2:0] stretch_q;
	logic wait_en_q;
	logic pointer_select_q;
	logic [15:0] primary_data_pointer_q;
	logic [15:0] secondary_data_pointer_q;
	logic [1:0] ta_stage_q;
	logic [1:0] ta_count_q;
	logic [7:0] rdata_q;
	logic [7:0] move_rdata_q;
	logic done_q;
	logic is_write_q;
	logic strobe_q;
	logic strobe_used_q;
	logic [5:0] strobe_left_q;
	ext_bus_t bus_q;
	logic [15:0] move_addr;
	logic last_clk;
	logic [5:0] strobe_clks;
	logic in_access;
	logic strobe_open;
	logic strobe_close;
	logic wait_seen;
	logic move_end;

	// Strobe width in clocks for a stretch value
	function automatic logic [5:0] strobe_width(input logic [2:0] s);
		if (s == 3'h0) begin
			strobe_width = 6'h02;
		end else begin
			strobe_width = {1'b0, s, 2'b00};
		end
	endfunction

	assign strobe_clks = strobe_width(stretch_q);
	assign last_clk = phase_q == 2'(CLK_PER_MC - 1);
	assign sel_ptr_o = pointer_select_q ? secondary_data_pointer_q : primary_data_pointer_q;
	always_comb begin
		if (move_kind_i == MOVE_READ_REG || move_kind_i == MOVE_WRITE_REG) begin
			move_addr = {port2_latch_i, work_reg_i};
		end else begin
			move_addr = sel_ptr_o;
		end
	end

	// Register writes; wait enable only inside an unlocked window
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			stretch_q <= STRETCH_RESET;
			wait_en_q <= 1'b0;
			pointer_select_q <= 1'b0;
			ta_stage_q <= 2'h0;
			ta_count_q <= 2'h0;
		end else if (clk_en_i) begin
			if (ta_count_q != 2'h0) begin
				ta_count_q <= ta_count_q - 2'h1;
			end
			if (reg_wr_i && reg_addr_i == TA_ADDR) begin
				if (reg_wdata_i == TA_KEY1) begin
					ta_stage_q <= 2'h1;
				end else if (reg_wdata_i == TA_KEY2 && ta_stage_q == 2'h1) begin
					ta_stage_q <= 2'h2;
					ta_count_q <= 2'(TA_WINDOW);
				end else begin
					ta_stage_q <= 2'h0;
				end
			end else if (reg_wr_i && reg_addr_i == PTR_SEL_ADDR) begin
				pointer_select_q <= reg_wdata_i[0];
			end else if (reg_wr_i && reg_addr_i == CLOCK_CTRL_ADDR) begin
				stretch_q <= reg_wdata_i[STRETCH_LSB +: 3];
			end else if (reg_wr_i && reg_addr_i == MEM_MAP_ADDR) begin
				if (ta_stage_q == 2'h2 && ta_count_q != 2'h0) begin
					wait_en_q <= reg_wdata_i[WAIT_EN_BIT];
				end
				ta_stage_q <= 2'h0;
			end
		end
	end

	// Register reads, data one cycle later
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h00;
		end else if (clk_en_i) begin
			if (!reg_rd_i) begin
				rdata_q <= 8'h00;
			end else if (reg_addr_i == PTR_SEL_ADDR) begin
				rdata_q <= {7'h00, pointer_select_q};
			end else if (reg_addr_i == CLOCK_CTRL_ADDR) begin
				rdata_q <= {CLOCK_CTRL_RESET[7:3], stretch_q};
			end else if (reg_addr_i == MEM_MAP_ADDR) begin
				rdata_q <= {wait_en_q, 7'h00};
			end else if (reg_addr_i == TA_ADDR) begin
				rdata_q <= {6'h00, ta_stage_q};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end
	assign reg_rdata_o = rdata_q;

	// Data pointer loads and increments act on the selected pointer
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			primary_data_pointer_q <= 16'h0000;
			secondary_data_pointer_q <= 16'h0000;
		end else if (clk_en_i) begin
			if (ptr_load_i) begin
				if (pointer_select_q) begin
					secondary_data_pointer_q <= ptr_load_val_i;
				end else begin
					primary_data_pointer_q <= ptr_load_val_i;
				end
			end else if (ptr_inc_i) begin
				if (pointer_select_q) begin
					secondary_data_pointer_q <= secondary_data_pointer_q + 16'h0001;
				end else begin
					primary_data_pointer_q <= primary_data_pointer_q + 16'h0001;
				end
			end
		end
	end

	// Elaboration guard: phase counter and sampling point assume four clocks per cycle
	if (CLK_PER_MC != 4 || SAMPLE_PHASE >= STROBE_END_PHASE) begin : g_cfg_check
		$error("Machine cycle constants do not fit the two bit phase counter");
	end

	// Access terms shared by the sequencer processes
	assign in_access = state_q == ST_ACCESS;
	assign strobe_open = in_access && !strobe_q && !strobe_used_q && phase_q == 2'h0;
	// Wait counts only at the third clock state just before the strobe would fall
	assign wait_seen = strobe_q && phase_q == SAMPLE_PHASE &&
		strobe_left_q <= 6'(CLK_PER_MC - 1) && wait_en_q && !port4_bit0_pin_n_i;
	assign strobe_close = strobe_q && strobe_left_q == 6'h01 && !wait_seen;
	assign move_end = in_access && last_clk && mc_left_q == 4'h1;

	// Sequencer state and clock phase within the machine cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
		end else if (clk_en_i) begin
			case (state_q)
				ST_IDLE: begin
					phase_q <= 2'h0;
					if (move_start_i) begin
						state_q <= ST_FETCH;
						phase_q <= 2'h1;
					end
				end
				ST_FETCH: begin
					phase_q <= phase_q + 2'h1;
					if (last_clk) begin
						state_q <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					phase_q <= phase_q + 2'h1;
					if (move_end) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					phase_q <= 2'h0;
				end
			endcase
		end
	end

	// Access machine cycles left; a sampled wait adds one more cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mc_left_q <= 4'h0;
		end else if (clk_en_i) begin
			if (state_q == ST_FETCH && last_clk) begin
				mc_left_q <= {1'b0, stretch_q} + 4'h1;
			end else if (wait_seen) begin
				mc_left_q <= mc_left_q + 4'h1;
			end else if (in_access && last_clk && !move_end) begin
				mc_left_q <= mc_left_q - 4'h1;
			end
		end
	end

	// Strobe timer; a sampled wait keeps the strobe open one more machine cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			strobe_q <= 1'b0;
			strobe_used_q <= 1'b0;
			strobe_left_q <= 6'h00;
		end else if (clk_en_i) begin
			if (state_q == ST_FETCH) begin
				strobe_used_q <= 1'b0;
			end
			if (strobe_open) begin
				strobe_q <= 1'b1;
				strobe_used_q <= 1'b1;
				strobe_left_q <= strobe_clks;
			end else if (strobe_close) begin
				strobe_q <= 1'b0;
				strobe_left_q <= 6'h00;
			end else if (wait_seen) begin
				strobe_left_q <= strobe_left_q + 6'(CLK_PER_MC - 1);
			end else if (strobe_q) begin
				strobe_left_q <= strobe_left_q - 6'h01;
			end
		end
	end

	// Address and write data latched at the start and held until the next move
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			is_write_q <= 1'b0;
			bus_q <= '{addr: 16'h0000, wdata: 8'h00, rd_n: 1'b1, wr_n: 1'b1};
		end else if (clk_en_i) begin
			if (state_q == ST_IDLE && move_start_i) begin
				is_write_q <= move_kind_i == MOVE_WRITE_PTR || move_kind_i == MOVE_WRITE_REG;
				bus_q.addr <= move_addr;
				bus_q.wdata <= move_wdata_i;
			end
			if (strobe_open) begin
				bus_q.rd_n <= is_write_q;
				bus_q.wr_n <= !is_write_q;
			end else if (strobe_close) begin
				bus_q.rd_n <= 1'b1;
				bus_q.wr_n <= 1'b1;
			end
		end
	end

	// Read data taken as the strobe closes; done marks the first idle clock after the move
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			move_rdata_q <= 8'h00;
			done_q <= 1'b0;
		end else if (clk_en_i) begin
			done_q <= move_end;
			if (strobe_close && !is_write_q) begin
				move_rdata_q <= ext_rdata_i;
			end
		end
	end

	assign move_busy_o = state_q != ST_IDLE;
	assign move_done_o = done_q;
	assign move_rdata_o = move_rdata_q;
	assign ext_bus_o = bus_q;
endmodule

/* bench/xdata_timing_asserts.sv */
// Port assertions for the external data access timing block
`timescale 1ns/1ps
module xdata_timing_asserts
	import xdata_timing_pkg::*;
(
	// Watched ports
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic move_start_i,
	input wire logic move_busy_o,
	input wire logic move_done_o,
	input wire logic ptr_load_i,
	input wire logic [15:0] ptr_load_val_i,
	input wire logic ptr_inc_i,
	input wire logic [15:0] sel_ptr_o,
	input wire ext_bus_t ext_bus_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire idle = ext_bus_o.rd_n && ext_bus_o.wr_n;
	wire take = move_start_i && !move_busy_o;
	wire ld = ptr_load_i && !reg_wr_i;
	wire inc = ptr_inc_i && !ptr_load_i && !reg_wr_i;
	sequence fetch_s; idle [*4]; endsequence
	sequence strobe_s; !idle ##1 !idle; endsequence
	chk_fetch_idle: assert property (take |=> fetch_s)
		else $error("strobe during fetch");
	chk_start_busy: assert property (take |=> move_busy_o)
		else $error("busy missing");
	chk_min_len: assert property (take |=> !move_done_o [*7])
		else $error("move too short");
	chk_strobe_min: assert property ($fell(idle) |-> strobe_s)
		else $error("strobe too short");
	chk_addr_hold: assert property (!idle && !$past(idle) |->
		$stable(ext_bus_o.addr) && $stable(ext_bus_o.wdata))
		else $error("bus moved under strobe");
	chk_done_idle: assert property (move_done_o |-> idle && !move_busy_o)
		else $error("done while active");
	chk_ptr_load: assert property (ld |=> sel_ptr_o == $past(ptr_load_val_i))
		else $error("pointer load");
	chk_ptr_inc: assert property (inc |=> sel_ptr_o == $past(sel_ptr_o) + 16'h0001)
		else $error("pointer increment");
	chk_sel_read: assert property (reg_rd_i && reg_addr_i == PTR_SEL_ADDR |=>
		reg_rdata_o[7:1] == 7'h00)
		else $error("select upper bits");
endmodule
bind xdata_timing xdata_timing_asserts xdata_timing_asserts_inst (.sys_clk_i, .sys_rst_i,
	.reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .move_start_i, .move_busy_o, .move_done_o,
	.ptr_load_i, .ptr_load_val_i, .ptr_inc_i, .sel_ptr_o, .ext_bus_o);

/* bench/xdata_mem_model.sv */
// Behavioural external data memory with a programmable wait line
`timescale 1ns/1ps
module xdata_mem_model
	import xdata_timing_pkg::*;
(
	// Bus side
	input wire logic sys_clk_i,
	input wire ext_bus_t bus_i,
	input wire logic [7:0] wait_clks_i,
	output logic [7:0] rdata_o,
	output logic wait_n_o
);
	logic [7:0] mem [256];
	logic [7:0] cnt = 8'h00;
	wire act = !(bus_i.rd_n && bus_i.wr_n);
	// Released data lines show the inverted low address byte, never the memory data
	assign rdata_o = bus_i.rd_n ? ~bus_i.addr[7:0] : mem[bus_i.addr[7:0]];
	// Wait low for the first strobe clocks, then released to its pull-up
	assign wait_n_o = !act || cnt >= wait_clks_i;
	always @(posedge sys_clk_i) begin
		cnt <= act ? cnt + 8'h01 : 8'h00;
		if (!bus_i.wr_n) mem[bus_i.addr[7:0]] <= bus_i.wdata;
	end
endmodule

/* bench/xdata_timing_bench.sv */
// Self-checking bench for the external data access timing block
`timescale 1ns/1ps
module xdata_timing_bench import xdata_timing_pkg::*;;
	logic sys_clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
	logic move_start_i = 0, ptr_load_i = 0, ptr_inc_i = 0;
	logic move_busy_o, move_done_o, port4_bit0_pin_n_i;
	logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, wait_clks = 0;
	logic [7:0] ext_rdata_i, reg_rdata_o, move_rdata_o;
	logic [15:0] ptr_load_val_i = 0, sel_ptr_o;
	move_kind_t move_kind_i = MOVE_READ_PTR;
	ext_bus_t ext_bus_o;
	int fail_count = 0, n_compared = 0;
	xdata_timing xdata_timing_inst (.sys_clk_i, .sys_rst_i, .clk_en_i(1'b1), .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .move_start_i, .move_kind_i,
		.move_wdata_i(8'hc3), .work_reg_i(8'h34), .port2_latch_i(8'h12), .ptr_load_i,
		.ptr_load_val_i, .ptr_inc_i, .move_busy_o, .move_done_o, .move_rdata_o, .sel_ptr_o,
		.ext_rdata_i, .port4_bit0_pin_n_i, .ext_bus_o);
	xdata_mem_model xdata_mem_model_inst (.sys_clk_i, .bus_i(ext_bus_o),
		.wait_clks_i(wait_clks), .rdata_o(ext_rdata_i), .wait_n_o(port4_bit0_pin_n_i));
	initial forever #50 sys_clk_i = ~sys_clk_i;
	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#2000000 fail_count++;
		end_of_test;
	end
	task automatic chk(input string what, input logic [15:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk("reg", {8'h00, exp}, {8'h00, reg_rdata_o});
		@(posedge sys_clk_i);
	endtask
	task automatic ptr(input logic ld, input logic [15:0] exp);
		ptr_load_i <= ld;
		ptr_inc_i <= !ld;
		@(posedge sys_clk_i);
		ptr_load_i <= 1'b0;
		ptr_inc_i <= 1'b0;
		#1 chk("ptr", exp, sel_ptr_o);
		@(posedge sys_clk_i);
	endtask
	// Kinds cycle so every read follows a write to the same place
	task automatic move(input int s, len, wid);
		int n, w;
		move_kind_t k;
		k = move_kind_t'(2'(s ^ 1));
		// The start edge itself is the first clock of the move
		n = 1;
		w = 0;
		move_kind_i <= k;
		move_start_i <= 1'b1;
		@(posedge sys_clk_i);
		move_start_i <= 1'b0;
		while (move_done_o !== 1'b1 && n < 300) begin
			@(posedge sys_clk_i);
			#1 n++;
			if (!(ext_bus_o.rd_n && ext_bus_o.wr_n)) begin
				w++;
				chk("addr", k[1] ? 16'h1234 : 16'h00a0, ext_bus_o.addr);
			end
		end
		chk("len", 16'(len), 16'(n));
		if (wid != 0) chk("strobe", 16'(wid), 16'(w));
		if (!k[0]) chk("rdata", 16'h00c3, {8'h00, move_rdata_o});
		@(posedge sys_clk_i);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		rd(CLOCK_CTRL_ADDR, 8'h01);
		wr(PTR_SEL_ADDR, 8'hff);
		rd(PTR_SEL_ADDR, 8'h01);
		ptr_load_val_i <= 16'hbeef;
		ptr(1'b1, 16'hbeef);
		ptr(1'b0, 16'hbef0);
		wr(PTR_SEL_ADDR, 8'h00);
		ptr_load_val_i <= 16'h00a0;
		ptr(1'b1, 16'h00a0);
		wait_clks <= 8'h0a;
		wr(MEM_MAP_ADDR, 8'h80);
		rd(MEM_MAP_ADDR, 8'h00);
		for (int s = 0; s < 8; s++) begin
			wr(CLOCK_CTRL_ADDR, 8'(s));
			move(s, (s + 2) * 4, s ? 4 * s : 2);
		end
		wr(TA_ADDR, TA_KEY1);
		wr(TA_ADDR, TA_KEY2);
		wr(MEM_MAP_ADDR, 8'h80);
		rd(MEM_MAP_ADDR, 8'h80);
		// Stretch one, then stretch zero: three waits add three cycles and twelve strobe clocks
		wr(CLOCK_CTRL_ADDR, 8'h01);
		move(1, 24, 16);
		wr(CLOCK_CTRL_ADDR, 8'h00);
		move(0, 20, 14);
		wait_clks <= 8'h00;
		move(0, 8, 2);
		end_of_test;
	end
endmodule
